// >>> design/ctah_device.sv
// Order intake, record keeping, reply formatting and serial link of the trunk handler.
//
// The AHB-Lite register port and the register offsets were decided locally.
`include "ctah_map.svh"
module ctah_device #(
  parameter int CYCLE_CLKS = `CTAH_CYCLE_NS / `CTAH_CLK_NS, // Program cycle length.
  parameter int FIFO_AW    = 4,                             // Input FIFO address width.
  parameter int NPSR       = 16                             // Pulsing state records.
) (
  // Clock and reset.
  input  wire logic   hclk,
  input  wire logic   hresetn,
  // Order and answer link.
  ctah_link_if.dev    lnk,
  // Serial channel to the channel bank controller.
  output logic        ser_tx,
  input  wire logic   ser_rx
);
  localparam int PW = $clog2(NPSR);
  // Complete control state of the device.
  typedef struct packed {
    ctah_pkg::ctah_dst_t st;
    logic [19:0] tick;       // Program cycle counter.
    logic [FIFO_AW:0] fwr;   // FIFO write pointer.
    logic [FIFO_AW:0] frd;   // FIFO read pointer.
    logic [2:0] pob_n;       // Buffer orders in hopper.
    logic [3:0] oth_n;       // Other orders in hopper.
    logic [2:0] pob_i;       // Next buffer order to run.
    logic [3:0] oth_i;       // Next other order to run.
    logic [4:0] rep_i;       // Count report word index.
    logic [4:0] mwp;         // Reply ring write pointer.
    logic [PW-1:0] psr_nx;   // Next free pulsing record.
    logic [4:0] cur_dg;      // Digroup of the last state change.
    logic [11:0] tx_cnt;     // Transmit bit timer.
    logic [3:0] tx_bit;      // Transmit bits left.
    logic [9:0] tx_sh;       // Transmit shifter.
    logic [11:0] rx_cnt;     // Receive bit timer.
    logic [3:0] rx_bit;      // Receive bits left.
    logic [8:0] rx_sh;       // Receive shifter.
    logic rx_pend;           // Received byte awaiting reply.
    logic [7:0] rx_byte;     // Received byte.
    logic [15:0] ans_data;   // Answer read data.
    logic ans_valid;         // Answer read strobe.
  } ctah_dstate_t;
  ctah_dstate_t s_reg, s_next;
  // Memories.
  logic [`CTAH_ORD_W-1:0] fifo_mem [2**FIFO_AW];
  logic [`CTAH_ORD_W-1:0] pob_hop [`CTAH_POB_SLOTS];
  logic [`CTAH_ORD_W-1:0] oth_hop [`CTAH_OTH_SLOTS];
  logic [31:0]  trk_rec [`CTAH_NTRK];      // Status, pending, translation, link bytes.
  logic [127:0] dg_rec [`CTAH_NDG];        // Message, status, alarms, error counts.
  logic [175:0] psr_rec [NPSR];            // Digits, call link, list pointers, states.
  logic [31:0]  tl_head [3];               // First and last pointers per timing list.
  logic [PW-1:0] link_tab [256];           // Call link number to record index.
  logic [15:0]  ev_cnt [`CTAH_CNT_WORDS];  // 32-byte event count block.
  logic [15:0]  prm [8];                   // 16-byte timing parameter block.
  logic [15:0]  ring [32];                 // Reply ring.
  logic [23:0]  insvc_reg;                 // In-service mask.
  logic [63:0]  call_reg;                  // Call address block, flags first.
  logic [`CTAH_NTRK-1:0] trk_lnk;          // Trunks that hold a pulsing record link; cleared at reset.
  // Memory write controls from the combinational block.
  logic fifo_we, hop_we, hop_pob, trk_we, dg_we, psr_we, tl_we, lt_we, ev_inc, ev_clr, prm_we, msg_we, ins_we, call_we;
  logic [3:0]  hop_idx, ev_idx, prm_idx;
  logic [8:0]  trk_idx;
  logic [31:0] trk_w;
  logic [175:0] psr_w;
  logic [15:0] msg_w;
  logic [7:0]  lt_idx;
  logic [63:0] call_w;
  logic [`CTAH_ORD_W-1:0] ord;
  logic [2:0]  cmd, mop;
  logic        op_ok, go_tx;

  ////////////////////////////////////////////////////////////////////////////
  // Map a trunk position 0-23 in its digroup onto channel numbers 4..27.
  function automatic logic [4:0] ch_of(input logic [4:0] p);
    ch_of = 5'(`CTAH_CH_FIRST + `CTAH_CH_STEP * (p % 5'd6) + p / 5'd6);
  endfunction
  // Accept host trunk numbers in the four quadrants and give a dense index.
  function automatic logic [9:0] trk_of(input logic [8:0] t);
    trk_of = {(t[6:0] < `CTAH_TRK_PER_Q), 9'(t[8:7] * `CTAH_TRK_PER_Q + t[6:0])};
  endfunction
  // Answer memory read decoder.
  function automatic logic [15:0] ans_word(input logic [5:0] a);
    if (a < `CTAH_A_TIMING_PARAMETER_BLOCK) ans_word = ring[a[4:0]];
    else if (a < `CTAH_A_CNT) ans_word = prm[a[2:0]];
    else if (a < `CTAH_A_INSVC) ans_word = ev_cnt[a[3:0]];
    else if (a < `CTAH_A_CALL) ans_word = a[0] ? {8'h00, insvc_reg[23:16]} : insvc_reg[15:0];
    else if (a < `CTAH_A_WPTR) ans_word = call_reg[16*a[1:0] +: 16];
    else ans_word = {11'h000, s_reg.mwp};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer, FIFO, hopper, order execution and serial link.
  always_comb
  begin
    logic [9:0] tk;
    logic [4:0] dg, pos;
    s_next = s_reg;
    {fifo_we, hop_we, hop_pob, trk_we, dg_we, psr_we, tl_we, lt_we} = '0;
    {ev_inc, ev_clr, prm_we, msg_we, ins_we, call_we, go_tx} = '0;
    hop_idx = '0; ev_idx = `CTAH_EV_EXEC; prm_idx = '0; lt_idx = '0;
    trk_w = '0; psr_w = '0; msg_w = '0; call_w = '0; op_ok = 1'b0;
    ord = s_reg.pob_i < s_reg.pob_n ? pob_hop[s_reg.pob_i[1:0]] : oth_hop[s_reg.oth_i];
    cmd = ord[`CTAH_CMD_HI:`CTAH_CMD_LO];
    mop = ord[`CTAH_MOP_HI:`CTAH_MOP_LO];
    tk = trk_of(ord[`CTAH_TRK_HI:0]);
    trk_idx = tk[8:0];
    dg = 5'(tk[8:0] / `CTAH_CH_PER_DG);
    pos = 5'(tk[8:0] % `CTAH_CH_PER_DG);
    s_next.tick = s_reg.tick + 20'h1;
    s_next.ans_valid = lnk.ans_rd;
    if (lnk.ans_rd) s_next.ans_data = ans_word(lnk.ans_addr);
    // Host writes are taken whenever there is room.
    if (lnk.order_wr && !lnk.order_full)
    begin
      fifo_we = 1'b1;
      s_next.fwr = s_reg.fwr + 1'b1;
    end
    unique case (s_reg.st)
      ctah_pkg::DS_IDLE:
        if (s_reg.tick >= 20'(CYCLE_CLKS - 1))
        begin
          s_next.tick = '0;
          s_next.st = ctah_pkg::DS_DRAIN;
          {s_next.pob_n, s_next.oth_n, s_next.pob_i, s_next.oth_i} = '0;
        end
      ctah_pkg::DS_DRAIN:
        // Empty the FIFO into the hopper; stop early only when a part is full.
        if (s_reg.frd == s_reg.fwr || s_reg.pob_n == 3'(`CTAH_POB_SLOTS)
            || s_reg.oth_n == 4'(`CTAH_OTH_SLOTS)) s_next.st = ctah_pkg::DS_EXEC;
        else
        begin
          hop_we = 1'b1;
          s_next.frd = s_reg.frd + 1'b1;
          hop_pob = !fifo_mem[s_reg.frd[FIFO_AW-1:0]][`CTAH_MBIT];
          hop_idx = hop_pob ? 4'(s_reg.pob_n) : s_reg.oth_n;
          if (hop_pob) s_next.pob_n = s_reg.pob_n + 3'h1;
          else s_next.oth_n = s_reg.oth_n + 4'h1;
        end
      ctah_pkg::DS_EXEC:
        if (s_reg.pob_i == s_reg.pob_n && s_reg.oth_i == s_reg.oth_n) s_next.st = ctah_pkg::DS_IDLE;
        else if (!(ord[`CTAH_MBIT] && mop == `CTAH_MOP_RDCNT) && !(s_reg.tx_bit != 4'h0
                 && !ord[`CTAH_MBIT] && cmd == `CTAH_CMD_STATE))
        begin
          if (s_reg.pob_i < s_reg.pob_n) s_next.pob_i = s_reg.pob_i + 3'h1;
          else s_next.oth_i = s_reg.oth_i + 4'h1;
          ev_inc = 1'b1;
          if (!ord[`CTAH_MBIT])
          begin
            // Operational: trunk must exist and be in service; digit and link orders also check its link flag.
            op_ok = tk[9] && insvc_reg[dg];
            trk_w = trk_rec[trk_idx];
            psr_w = psr_rec[link_tab[ord[`CTAH_ARG_HI:`CTAH_ARG_LO]]];
            call_w = {4'h0, 1'b0, pos, 1'b0, dg, 7'h00, trk_idx, 16'h0007};
            unique case (cmd)
              `CTAH_CMD_STATE:
              begin
                trk_w[15:8] = {1'b1, 3'h0, ord[12:9]}; // Pending change with process marker.
                go_tx = op_ok;
                s_next.cur_dg = dg;
              end
              `CTAH_CMD_DIGIT:
              begin
                op_ok = op_ok && trk_lnk[trk_idx];
                psr_w[175:168] = {4'h0, ord[16:13]};
                psr_w[47:40] = 8'h01; // Activity: outpulsing.
              end
              `CTAH_CMD_LINK:
              begin
                op_ok = op_ok && !trk_lnk[trk_idx] && s_reg.psr_nx != PW'(NPSR - 1);
                if (tk[9] && s_reg.psr_nx == PW'(NPSR - 1))
                begin
                  ev_idx = `CTAH_EV_NOPSR;
                end
                lt_we = op_ok;
                lt_idx = ord[`CTAH_ARG_HI:`CTAH_ARG_LO];
                trk_w[31:24] = 8'(s_reg.psr_nx);
                trk_w[1] = 1'b1;
                psr_w = '0;
                psr_w[111:104] = ord[`CTAH_ARG_HI:`CTAH_ARG_LO]; // Call register link.
                psr_w[63:48] = 16'hffff; // Short list next pointer: end.
                tl_we = op_ok;
                if (op_ok) s_next.psr_nx = s_reg.psr_nx + 1'b1;
              end
              `CTAH_CMD_STPS: trk_w[0] = 1'b1;
              default: op_ok = 1'b0;
            endcase
            trk_we = op_ok;
            psr_we = op_ok && (cmd == `CTAH_CMD_DIGIT || cmd == `CTAH_CMD_LINK);
            call_we = op_ok;
            if (!op_ok && ev_idx != `CTAH_EV_NOPSR) ev_idx = `CTAH_EV_DISCARD;
            msg_we = op_ok;
            msg_w = {1'b0, `CTAH_MT_REPLY, cmd, trk_idx};
          end
          else
          begin
            // Maintenance orders.
            unique case (mop)
              `CTAH_MOP_TIMING_PARAMETER_BLOCK: begin prm_we = 1'b1; prm_idx = ord[11:8]; end
              `CTAH_MOP_CLRCNT: ev_clr = 1'b1;
              `CTAH_MOP_INSVC: ins_we = ord[4:0] < 5'(`CTAH_NDG);
              default: ;
            endcase
            msg_we = 1'b1;
            msg_w = {3'b100, 10'h000, mop};
          end
        end
        else if (ord[`CTAH_MBIT] && mop == `CTAH_MOP_RDCNT)
        begin
          // A count report order; a state change meeting a busy transmitter just waits here.
          s_next.st = ctah_pkg::DS_REPORT;
          s_next.rep_i = '0;
        end
      ctah_pkg::DS_REPORT:
      begin
        // Header then sixteen count words.
        msg_we = 1'b1;
        msg_w = s_reg.rep_i == 5'h0 ? {3'b110, 1'b0, 4'(`CTAH_CNT_WORDS + 1 - 2), `CTAH_TY_CNT}
                                    : ev_cnt[4'(s_reg.rep_i - 5'h1)];
        s_next.rep_i = s_reg.rep_i + 5'h1;
        if (s_reg.rep_i == 5'(`CTAH_CNT_WORDS))
        begin
          s_next.st = ctah_pkg::DS_EXEC;
          s_next.oth_i = s_reg.oth_i + 4'h1;
        end
      end
    endcase
    // A received byte is reported once the order path leaves the ring free.
    if (s_reg.rx_pend && !msg_we)
    begin
      msg_we = 1'b1;
      msg_w = {1'b0, `CTAH_MT_DIGIT, 4'h0, s_reg.rx_byte};
      s_next.rx_pend = 1'b0;
      dg_we = 1'b1;
    end
    if (msg_we) s_next.mwp = s_reg.mwp + 5'h1;
    // Serial transmitter: start bit, 8 data bits LSB first, stop bit.
    if (go_tx)
    begin
      s_next.tx_sh = {1'b1, ch_of(pos), ord[11:9], 1'b0};
      s_next.tx_bit = 4'd10;
      s_next.tx_cnt = 12'(`CTAH_BIT_CLKS - 1);
    end
    else if (s_reg.tx_bit != 4'h0)
      if (s_reg.tx_cnt == 12'h0)
      begin
        s_next.tx_sh = {1'b1, s_reg.tx_sh[9:1]};
        s_next.tx_bit = s_reg.tx_bit - 4'h1;
        s_next.tx_cnt = 12'(`CTAH_BIT_CLKS - 1);
      end
      else s_next.tx_cnt = s_reg.tx_cnt - 12'h1;
    // Serial receiver: sample at mid-bit after a falling start edge.
    if (s_reg.rx_bit == 4'h0)
    begin
      if (!ser_rx)
      begin
        s_next.rx_bit = 4'd10;
        s_next.rx_cnt = 12'(`CTAH_BIT_CLKS / 2);
      end
    end
    else if (s_reg.rx_cnt == 12'h0)
    begin
      s_next.rx_sh = {ser_rx, s_reg.rx_sh[8:1]};
      s_next.rx_bit = s_reg.rx_bit - 4'h1;
      s_next.rx_cnt = 12'(`CTAH_BIT_CLKS - 1);
      if (s_reg.rx_bit == 4'h1)
      begin
        s_next.rx_pend = ser_rx;
        s_next.rx_byte = s_reg.rx_sh[8:1];
      end
    end
    else s_next.rx_cnt = s_reg.rx_cnt - 12'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_reg <= '0;
      s_reg.tx_sh <= 10'h3ff; // Line idles high.
    end
    else s_reg <= s_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory writes; records come up unknown, only the in-service mask, tl_head[0] and link flags reset.
  always_ff @(posedge hclk)
  begin
    if (fifo_we) fifo_mem[s_reg.fwr[FIFO_AW-1:0]] <= lnk.order_data;
    if (hop_we && hop_pob) pob_hop[hop_idx[1:0]] <= fifo_mem[s_reg.frd[FIFO_AW-1:0]];
    if (hop_we && !hop_pob) oth_hop[hop_idx] <= fifo_mem[s_reg.frd[FIFO_AW-1:0]];
    if (trk_we) trk_rec[trk_idx] <= trk_w;
    if (psr_we && cmd == `CTAH_CMD_LINK) psr_rec[s_reg.psr_nx] <= psr_w;
    if (psr_we && cmd == `CTAH_CMD_DIGIT) psr_rec[link_tab[lt_idx]] <= psr_w;
    if (lt_we) link_tab[lt_idx] <= s_reg.psr_nx;
    if (tl_we) tl_head[0] <= {(tl_head[0][31:16] == 16'hffff ? 16'(s_reg.psr_nx) : tl_head[0][31:16]),
                              16'(s_reg.psr_nx)};
    if (dg_we) dg_rec[s_reg.cur_dg] <= {s_reg.rx_byte, dg_rec[s_reg.cur_dg][119:0]};
    if (prm_we) prm[prm_idx[3:1]][8*prm_idx[0] +: 8] <= ord[7:0];
    if (msg_we) ring[s_reg.mwp] <= msg_w;
    if (call_we) call_reg <= call_w;
    for (int i = 0; i < `CTAH_CNT_WORDS; i++)
      if (ev_clr) ev_cnt[i] <= 16'h0000;
      else if (ev_inc && ev_idx == 4'(i)) ev_cnt[i] <= ev_cnt[i] + 16'h1;
    if (!hresetn) insvc_reg <= 24'h000000;
    else if (ins_we) insvc_reg[ord[4:0]] <= ord[5];
    if (!hresetn) tl_head[0] <= 32'hffffffff;
    // Link flags live apart from the records, which come up unknown.
    if (!hresetn) trk_lnk <= '0;
    else if (lt_we) trk_lnk[trk_idx] <= 1'b1;
  end

  // Handshake and data outputs.
  assign lnk.order_full = (s_reg.fwr ^ s_reg.frd) == {1'b1, {FIFO_AW{1'b0}}};
  assign lnk.ans_data   = s_reg.ans_data;
  assign lnk.ans_valid  = s_reg.ans_valid;
  assign ser_tx         = s_reg.tx_sh[0];
endmodule

// >>> design/ctah_map.svh
// Offsets, field positions and timing counts of the carrier trunk order handler.
`ifndef CTAH_MAP_SVH
`define CTAH_MAP_SVH
`define CTAH_ORD_W      23
`define CTAH_MBIT       17
`define CTAH_CMD_HI     22
`define CTAH_CMD_LO     20
`define CTAH_ARG_HI     16
`define CTAH_ARG_LO     9
`define CTAH_TRK_HI     8
`define CTAH_MOP_HI     16
`define CTAH_MOP_LO     14
`define CTAH_CMD_STATE  3'h1
`define CTAH_CMD_DIGIT  3'h2
`define CTAH_CMD_LINK   3'h3
`define CTAH_CMD_STPS   3'h5
`define CTAH_MOP_TIMING_PARAMETER_BLOCK  3'h0
`define CTAH_MOP_RDCNT  3'h1
`define CTAH_MOP_CLRCNT 3'h2
`define CTAH_MOP_INSVC  3'h3
`define CTAH_POB_SLOTS  4
`define CTAH_OTH_SLOTS  11
`define CTAH_TRK_PER_Q  7'h78
`define CTAH_NDG        20
`define CTAH_NTRK       480
`define CTAH_CH_PER_DG  24
`define CTAH_CH_FIRST   5'h04
`define CTAH_CH_STEP    5'h04
`define CTAH_CH_LAST    5'h1b
`define CTAH_CLK_NS     25
`define CTAH_CYCLE_NS   10000000
`define CTAH_BIT_NS     50000
`define CTAH_BIT_CLKS   ((`CTAH_BIT_NS) / (`CTAH_CLK_NS))
`define CTAH_A_TIMING_PARAMETER_BLOCK    6'h20
`define CTAH_A_CNT      6'h28
`define CTAH_A_INSVC    6'h38
`define CTAH_A_CALL     6'h3a
`define CTAH_A_WPTR     6'h3f
`define CTAH_EV_DISCARD 4'h0
`define CTAH_EV_EXEC    4'h1
`define CTAH_EV_NOPSR   4'h2
`define CTAH_EV_FRAME   4'h3
`define CTAH_MT_DIGIT   3'h1
`define CTAH_MT_REPLY   3'h7
`define CTAH_TY_CNT     8'h01
`define CTAH_CNT_WORDS  16
`define CTAH_R_ORDER    4'h0
`define CTAH_R_STATUS   4'h4
`define CTAH_R_MSG      4'h8
`endif

// >>> design/ctah_pkg.sv
// Types shared by both ends of the carrier trunk order handler.
package ctah_pkg;
  // Device sequencer states, Gray coded except on the EXEC to IDLE step.
  typedef enum logic [1:0] {DS_IDLE = 2'b00, DS_DRAIN = 2'b01, DS_EXEC = 2'b11, DS_REPORT = 2'b10} ctah_dst_t;
  // Host bus-side states.
  typedef enum logic [1:0] {HS_IDLE = 2'b00, HS_WAIT = 2'b01, HS_DONE = 2'b11} ctah_hst_t;
endpackage

// >>> design/ctah_link_if.sv
// Link between the central processor end and the order handler device.
interface ctah_link_if (input wire logic hclk, input wire logic hresetn);
  logic        order_wr;   // Host pushes one order.
  logic [22:0] order_data; // Order word.
  logic        order_full; // Device input FIFO full.
  logic        ans_rd;     // Host reads one answer word.
  logic [5:0]  ans_addr;   // Answer memory word address.
  logic [15:0] ans_data;   // Answer word, one cycle after ans_rd.
  logic        ans_valid;  // Marks ans_data.
  modport dev  (input order_wr, order_data, ans_rd, ans_addr, output order_full, ans_data, ans_valid);
  modport host (output order_wr, order_data, ans_rd, ans_addr, input order_full, ans_data, ans_valid);
endinterface

// >>> design/ctah_host.sv
// Central processor end: AHB-Lite registers turned into orders and answer reads.
`include "ctah_map.svh"
module ctah_host (
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Link to the device.
  ctah_link_if.host        lnk
);
  // Complete state of the host end.
  typedef struct packed {
    ctah_pkg::ctah_hst_t st;
    logic        wr;       // Captured write flag.
    logic [3:0]  reg_a;    // Captured register offset.
    logic [4:0]  rd_ptr;   // Next reply ring word.
    logic [22:0] ord;      // Order to push.
    logic        push;     // Push pending.
    logic        ans_rd;   // Answer read strobe.
    logic [5:0]  ans_addr; // Answer address.
    logic [31:0] hrdata;   // Read data.
  } ctah_hstate_t;
  ctah_hstate_t s_reg, s_next;

  ////////////////////////////////////////////////////////////////////////////
  // Bus sequencer: each access costs at least one wait state.
  always_comb
  begin
    s_next = s_reg;
    s_next.ans_rd = 1'b0;
    unique case (s_reg.st)
      ctah_pkg::HS_IDLE:
        if (hsel && htrans[1] && hready)
        begin
          s_next.st = ctah_pkg::HS_WAIT;
          s_next.wr = hwrite;
          s_next.reg_a = haddr[3:0];
        end
      ctah_pkg::HS_WAIT:
        if (s_reg.wr)
        begin
          // Orders go out as written; other writes are dropped.
          s_next.ord = hwdata[22:0];
          s_next.push = s_reg.reg_a == `CTAH_R_ORDER;
          s_next.st = ctah_pkg::HS_DONE;
        end
        else if (s_reg.reg_a == `CTAH_R_MSG || s_reg.reg_a == `CTAH_R_STATUS)
        begin
          if (!s_reg.ans_rd && !lnk.ans_valid)
          begin
            s_next.ans_rd = 1'b1;
            s_next.ans_addr = s_reg.reg_a == `CTAH_R_MSG ? {1'b0, s_reg.rd_ptr} : `CTAH_A_WPTR;
          end
          if (lnk.ans_valid)
          begin
            s_next.hrdata = s_reg.reg_a == `CTAH_R_MSG ? {16'h0000, lnk.ans_data}
                          : {16'h0000, lnk.ans_data[4:0], s_reg.rd_ptr, 5'h00, lnk.order_full};
            if (s_reg.reg_a == `CTAH_R_MSG) s_next.rd_ptr = s_reg.rd_ptr + 5'h1;
            s_next.st = ctah_pkg::HS_DONE;
          end
        end
        else
        begin
          s_next.hrdata = 32'h00000000; // Unmapped read.
          s_next.st = ctah_pkg::HS_DONE;
        end
      ctah_pkg::HS_DONE:
        // Hold the push until the device FIFO has room.
        if (!(s_reg.push && lnk.order_full))
        begin
          s_next.push = 1'b0;
          s_next.st = ctah_pkg::HS_IDLE;
        end
      default: s_next.st = ctah_pkg::HS_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn) s_reg <= '0;
    else s_reg <= s_next;
  end

  // Outputs.
  assign hreadyout      = s_reg.st == ctah_pkg::HS_IDLE || s_next.st == ctah_pkg::HS_IDLE;
  assign hresp          = 1'b0;
  assign hrdata         = s_reg.hrdata;
  assign lnk.order_wr   = s_reg.push && s_reg.st == ctah_pkg::HS_DONE && !lnk.order_full;
  assign lnk.order_data = s_reg.ord;
  assign lnk.ans_rd     = s_reg.ans_rd;
  assign lnk.ans_addr   = s_reg.ans_addr;
endmodule

// >>> tb/ctah_link_asserts.sv
// Concurrent checks on the link between the host and device ends.
module ctah_link_asserts (
  // Clock and reset.
  input wire logic        hclk,
  input wire logic        hresetn,
  // Link signals.
  input wire logic        order_wr,
  input wire logic [22:0] order_data,
  input wire logic        order_full,
  input wire logic        ans_rd,
  input wire logic [5:0]  ans_addr,
  input wire logic [15:0] ans_data,
  input wire logic        ans_valid
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic ring_q; // A read of the reply ring is in flight.
  logic ring;   // A reply ring word stands on the answer data.
  // Remembers whether the last read asked for the reply ring.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ring_q <= 1'b0;
    else
      ring_q <= ans_rd && (ans_addr < 6'h20);
  end
  assign ring = ring_q && ans_valid;
  a_answer_follows: assert property (ans_rd |=> ans_valid) else $error("answer missing");
  a_answer_cause: assert property (ans_valid |-> $past(ans_rd)) else $error("answer unasked");
  a_answer_single: assert property (ans_valid |=> !ans_valid) else $error("answer too long");
  a_push_room: assert property (order_wr |-> !order_full) else $error("push into full queue");
  a_push_pulse: assert property (order_wr |=> !order_wr) else $error("push not a pulse");
  a_op_reply_code: assert property (ring && !ans_data[15] && ans_data[14:12] == 3'h7
    |-> ans_data[11:9] inside {3'h1, 3'h2, 3'h3, 3'h5}) else $error("reply for bad code");
  a_maint_single: assert property (ring && ans_data[15:14] == 2'b10 |-> ans_data[13:3] == 11'h0)
    else $error("single maintenance form");
  a_multi_length: assert property (ring && ans_data[15:14] == 2'b11 |-> ans_data[11:8] == 4'hf)
    else $error("length field wrong");
  a_serial_reply: assert property (ring && ans_data[15:12] == 4'h1 |-> ans_data[11:8] == 4'h0)
    else $error("serial reply form");
  c_multi: cover property (ring && ans_data[15:14] == 2'b11);
  c_serial: cover property (ring && ans_data[15:12] == 4'h1);
  c_push: cover property (order_wr);
endmodule

// >>> tb/tb_carrier_trunk_order_handler.sv
// Testbench joining the host and device ends of the trunk order handler.
module tb_carrier_trunk_order_handler;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'b0;     // Bus clock, 40 MHz.
  logic        hresetn = 1'b0;  // Active low reset.
  logic        hsel = 1'b0;     // Slave select.
  logic [31:0] haddr = 32'h0;   // Bus address.
  logic [1:0]  htrans = 2'h0;   // Transfer kind.
  logic        hwrite = 1'b0;   // Write strobe.
  logic [31:0] hwdata = 32'h0;  // Write data.
  logic        hreadyout;       // Slave ready, also the bus ready.
  logic        hresp;           // Slave response.
  logic [31:0] hrdata;          // Read data.
  logic        ser_tx;          // Serial line, looped back.
  logic [31:0] r;               // Last read word.
  int          bad_count = 0;   // Mismatches.
  int          compares = 0;    // Comparisons.
  always #12.5 hclk = ~hclk;
  ctah_link_if lnk_i (.hclk(hclk), .hresetn(hresetn));
  ctah_host ctah_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .lnk(lnk_i.host));
  ctah_device #(.CYCLE_CLKS(200)) ctah_device_i (.hclk(hclk), .hresetn(hresetn), .lnk(lnk_i.dev),
    .ser_tx(ser_tx), .ser_rx(ser_tx));
  ctah_link_asserts ctah_link_asserts_i (.hclk(hclk), .hresetn(hresetn), .order_wr(lnk_i.order_wr),
    .order_data(lnk_i.order_data), .order_full(lnk_i.order_full), .ans_rd(lnk_i.ans_rd),
    .ans_addr(lnk_i.ans_addr), .ans_data(lnk_i.ans_data), .ans_valid(lnk_i.ans_valid));
  ////////////////////////////////////////////////////////////////////////////////
  // Prints the verdict and ends the run.
  task automatic wrap_up();
    if (bad_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Waits, bounded, until ready stands high before the next rising edge.
  task automatic rdy();
    int n;
    n = 0;
    @(negedge hclk);
    while (hreadyout !== 1'b1 && n < 100)
    begin
      @(negedge hclk);
      n++;
    end
    if (n >= 100)
    begin
      bad_count++;
      wrap_up();
    end
  endtask
  // One single transfer: address phase, then data phase.
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    rdy();
    @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    r = hrdata;
    compares++;
    if (hresp !== 1'b0)
    begin
      bad_count++;
      $display("[ERR] hresp expected 0 seen %b", hresp);
    end
    @(posedge hclk);
  endtask
  // Compares one answer word.
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Two batches of orders, each followed by reading the reply ring back in order.
  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b1, 32'h0, 32'h28000);
    xfer(1'b1, 32'h0, 32'h2c020);
    repeat (400) @(posedge hclk);
    xfer(1'b1, 32'h0, 32'h300405);
    repeat (400) @(posedge hclk);
    xfer(1'b0, 32'h8, 32'h0);
    chk("msg_clear", 16'h8002, r[15:0]);
    xfer(1'b0, 32'h8, 32'h0);
    chk("msg_insvc", 16'h8003, r[15:0]);
    xfer(1'b0, 32'h8, 32'h0);
    chk("msg_link", 16'h7605, r[15:0]);
    xfer(1'b0, 32'h4, 32'h0);
    chk("status", 16'h18c0, r[15:0]);
    xfer(1'b0, 32'hc, 32'h0);
    chk("unmapped", 16'h0, r[15:0]);
    xfer(1'b1, 32'h0, 32'h400005);
    xfer(1'b1, 32'h0, 32'h100a05);
    xfer(1'b1, 32'h0, 32'h100a78);
    xfer(1'b1, 32'h0, 32'h500005);
    xfer(1'b1, 32'h0, 32'h24000);
    repeat (25000) @(posedge hclk);
    xfer(1'b0, 32'h8, 32'h0);
    chk("msg_state", 16'h7205, r[15:0]);
    xfer(1'b0, 32'h8, 32'h0);
    chk("msg_serial", 16'h10c5, r[15:0]);
    xfer(1'b0, 32'h8, 32'h0);
    chk("msg_start", 16'h7a05, r[15:0]);
    xfer(1'b0, 32'h8, 32'h0);
    chk("msg_header", 16'hcf01, r[15:0]);
    xfer(1'b0, 32'h8, 32'h0);
    chk("count_discard", 16'h0002, r[15:0]);
    repeat (15) xfer(1'b0, 32'h8, 32'h0);
    wrap_up();
  end
endmodule
